// [logic/gfs_pkg.sv]
// Purpose: constants shared by the gating and fault supervisor
// Assumes: 20 MHz ref_clk, samples as signed codes on the same clock
// Notes:   limits are given in physical units and scaled to codes here
package gfs_pkg;

  // ----------------------------------------------------------------
  // clock and sampling rates
  // ----------------------------------------------------------------
  localparam int GFS_CLK_HZ       = 20_000_000;
  localparam int GFS_FAST_KSPS    = 150;
  localparam int GFS_FAST_DIV     = GFS_CLK_HZ / (GFS_FAST_KSPS * 1000);
  localparam int GFS_SLOW_SPS     = 1000;
  localparam int GFS_SLOW_DIV     = GFS_CLK_HZ / GFS_SLOW_SPS;
  localparam int GFS_DIV_W        = 16;

  // ----------------------------------------------------------------
  // sample codes and scaling
  // ----------------------------------------------------------------
  localparam int GFS_SMP_W        = 13;
  localparam int GFS_I_PER_A      = 10;   // 0.1 A per code
  localparam int GFS_V_PER_V      = 2;    // 0.5 V per code
  localparam int GFS_T_PER_C      = 10;   // 0.1 degC per code
  localparam int GFS_S_PER_V10    = 10;   // 10 mV per code, in 0.1 V
  localparam int GFS_LEG_I_A      = 25;
  localparam int GFS_BUS_V_V      = 420;
  localparam int GFS_TEMP_C       = 90;
  localparam int GFS_SUP_LO_V10   = 45;
  localparam int GFS_SUP_HI_V10   = 55;
  localparam int GFS_LEG_I_LIM    = GFS_LEG_I_A * GFS_I_PER_A;
  localparam int GFS_BUS_V_LIM    = GFS_BUS_V_V * GFS_V_PER_V;
  localparam int GFS_TEMP_LIM     = GFS_TEMP_C * GFS_T_PER_C;
  localparam int GFS_SUP_LO_LIM   = GFS_SUP_LO_V10 * GFS_S_PER_V10;
  localparam int GFS_SUP_HI_LIM   = GFS_SUP_HI_V10 * GFS_S_PER_V10;
  localparam int GFS_SMP_MIN      = -(2 ** (GFS_SMP_W - 1));
  localparam int GFS_SMP_MAX      = (2 ** (GFS_SMP_W - 1)) - 1;

  // ----------------------------------------------------------------
  // monitor channels and fault bits
  // ----------------------------------------------------------------
  localparam int GFS_NFAST        = 2;
  localparam int GFS_NSLOW        = 3;
  localparam int GFS_F_VBUS       = 0;
  localparam int GFS_F_ILEG       = 1;
  localparam int GFS_S_T1         = 0;
  localparam int GFS_S_T2         = 1;
  localparam int GFS_S_SUP        = 2;
  localparam int GFS_NFLT         = GFS_NFAST + GFS_NSLOW;

  // ----------------------------------------------------------------
  // gating: bit0 A high, bit1 A low, bit2 B high, bit3 B low
  // ----------------------------------------------------------------
  localparam int GFS_NGATE        = 4;
  localparam logic [3:0] GFS_GATE_BLOCK  = 4'h0;
  localparam logic [3:0] GFS_GATE_BYPASS = 4'hA;
  localparam int GFS_IN_CMD_A     = 0;
  localparam int GFS_IN_CMD_B     = 1;
  localparam int GFS_IN_EN_A      = 2;
  localparam int GFS_IN_EN_B      = 3;
  localparam int GFS_G_AH         = 0;
  localparam int GFS_G_AL         = 1;
  localparam int GFS_G_BH         = 2;
  localparam int GFS_G_BL         = 3;

  typedef enum logic {
    GFS_GM_DIRECT = 1'b0,
    GFS_GM_CODED  = 1'b1
  } gfs_gmode_t;

endpackage : gfs_pkg

// [logic/gfs_mon_if.sv]
// Purpose: carries samples and limits to a monitor, and its out-of-window flags back
// Assumes: all signals on ref_clk
// Notes:   one instance per monitor unit
`timescale 1ns/10ps
interface gfs_mon_if #(
  parameter int N = 2,
  parameter int W = 13
);
  logic                  sample_stb;
  logic [N-1:0][W-1:0]   sample;
  logic [N-1:0][W-1:0]   lo;
  logic [N-1:0][W-1:0]   hi;
  logic [N-1:0]          over;

  modport mon (
    input  sample_stb,
    input  sample,
    input  lo,
    input  hi,
    output over
  );
  modport sup (
    output sample_stb,
    output sample,
    output lo,
    output hi,
    input  over
  );
endinterface : gfs_mon_if

// [logic/gfs_monitor.sv]
// Purpose: limit check of N signed sample channels on each sample strobe
// Assumes: strobe is a one-cycle enable from a divider
// Notes:   a flag holds the verdict of the latest sample of its channel
`timescale 1ns/10ps
module gfs_monitor
  import gfs_pkg::*;
#(
  parameter int N = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  gfs_mon_if.mon   mon
);

  logic [N-1:0] hit;
  logic [N-1:0] over_r;
  logic [N-1:0] over_nxt;

  // ----------------------------------------------------------------
  // per channel window compare
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign hit[i] = ($signed(mon.sample[i]) > $signed(mon.hi[i])) ||
                    ($signed(mon.sample[i]) < $signed(mon.lo[i]));
  end

  always_comb begin
    over_nxt = mon.sample_stb ? hit : over_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      over_r <= '0;
    end else begin
      over_r <= over_nxt;
    end
  end

  assign mon.over = over_r;

endmodule : gfs_monitor

// [logic/gfs_supervisor.sv]
// Purpose: gating and fault supervisor of a half/full-bridge module
// Assumes: optical inputs and ack buttons are asynchronous pins;
//          measurement codes come from converter logic on ref_clk
// Notes:   faults latch until the matching button is pressed
//
// Notes on behaviour
// (RL1) in direct mode each optical input drives its own gate output.
// (RL2) gate outputs are built from the received inputs, decoded if coded.
// (RL3) the fast monitor checks bus voltage and leg current at ~150 ksps.
// (RL4) the slow monitor checks temperatures and supply at 1 ksps.
// (RL5) default trips are |I| > 25 A, bus > 420 V, heatsink > 90 degC.
// (RL6) the 5 V supply trips below 4.5 V or above 5.5 V.
// (RL7) any fault forces all switches off, or bypass if its cause allows.
// (RL8) status flags are derived from the monitor fault indications.
// (RL9) the global error output is active low and drops on any fault.
// (RL10) a tripped fault stays latched until its button is pressed.
// (RL11) error and forced state follow the OR of all latched faults.
`timescale 1ns/10ps
module gfs_supervisor
  import gfs_pkg::*;
#(
  parameter int SLOW_DIV    = GFS_SLOW_DIV,
  parameter int LEG_I_LIM   = GFS_LEG_I_LIM,
  parameter int BUS_V_LIM   = GFS_BUS_V_LIM,
  parameter int TEMP_LIM    = GFS_TEMP_LIM,
  parameter int SUP_LO_LIM  = GFS_SUP_LO_LIM,
  parameter int SUP_HI_LIM  = GFS_SUP_HI_LIM
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic [GFS_NGATE-1:0]  opt_gate_in,
  input  wire logic                  gate_mode,
  input  wire logic [GFS_NFLT-1:0]   bypass_cause_mask,
  input  wire logic [GFS_SMP_W-1:0]  bus_voltage,
  input  wire logic [GFS_SMP_W-1:0]  leg_current,
  input  wire logic [GFS_SMP_W-1:0]  heatsink_temp1,
  input  wire logic [GFS_SMP_W-1:0]  heatsink_temp2,
  input  wire logic [GFS_SMP_W-1:0]  main_supply_voltage,
  input  wire logic [GFS_NFLT-1:0]   ack_btn,
  output      logic [GFS_NGATE-1:0]  gate_out,
  output      logic                  global_error_n,
  output      logic [GFS_NFLT-1:0]   fault_latched,
  output      logic [GFS_NFLT-1:0]   fault_live,
  output      logic                  fault_fast,
  output      logic                  fault_slow,
  output      logic                  fast_sample_stb,
  output      logic                  slow_sample_stb
);

  // ----------------------------------------------------------------
  // limits as sample codes
  // ----------------------------------------------------------------
  localparam logic [GFS_SMP_W-1:0] ILIM_HI = GFS_SMP_W'(LEG_I_LIM);
  localparam logic [GFS_SMP_W-1:0] ILIM_LO = GFS_SMP_W'(-LEG_I_LIM);
  localparam logic [GFS_SMP_W-1:0] VLIM_HI = GFS_SMP_W'(BUS_V_LIM);
  localparam logic [GFS_SMP_W-1:0] TLIM_HI = GFS_SMP_W'(TEMP_LIM);
  localparam logic [GFS_SMP_W-1:0] SLIM_HI = GFS_SMP_W'(SUP_HI_LIM);
  localparam logic [GFS_SMP_W-1:0] SLIM_LO = GFS_SMP_W'(SUP_LO_LIM);
  localparam logic [GFS_SMP_W-1:0] SMIN    = GFS_SMP_W'(GFS_SMP_MIN);
  localparam logic [GFS_DIV_W-1:0] FAST_LAST =
    GFS_DIV_W'(GFS_FAST_DIV - 1);
  localparam logic [GFS_DIV_W-1:0] SLOW_LAST = GFS_DIV_W'(SLOW_DIV - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [GFS_NGATE-1:0] gin_m_r;
  logic [GFS_NGATE-1:0] gin_s_r;
  logic [GFS_NFLT-1:0]  ack_m_r;
  logic [GFS_NFLT-1:0]  ack_s_r;
  logic [GFS_NFLT-1:0]  ack_d_r;
  logic [GFS_NFLT-1:0]  ack_edge;

  // the first stage feeds only the second; edges use stage two and its delayed copy
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gin_m_r <= GFS_GATE_BLOCK;
      gin_s_r <= GFS_GATE_BLOCK;
      ack_m_r <= '0;
      ack_s_r <= '0;
      ack_d_r <= '0;
    end else begin
      gin_m_r <= opt_gate_in;
      gin_s_r <= gin_m_r;
      ack_m_r <= ack_btn;
      ack_s_r <= ack_m_r;
      ack_d_r <= ack_s_r;
    end
  end

  // a held button clears once; a fault still present re-latches
  assign ack_edge = ack_s_r & ~ack_d_r;

  // ----------------------------------------------------------------
  // sample rate dividers
  // ----------------------------------------------------------------
  logic [GFS_DIV_W-1:0] fdiv_r;
  logic [GFS_DIV_W-1:0] fdiv_nxt;
  logic [GFS_DIV_W-1:0] sdiv_r;
  logic [GFS_DIV_W-1:0] sdiv_nxt;
  logic                 fstb_r;
  logic                 fstb_nxt;
  logic                 sstb_r;
  logic                 sstb_nxt;

  // fast rate rounds down to 133 cycles, slightly above 150 ksps
  always_comb begin
    fstb_nxt = (fdiv_r == FAST_LAST);                   // see RL3
    fdiv_nxt = fstb_nxt ? '0 : fdiv_r + 1'b1;
    sstb_nxt = (sdiv_r == SLOW_LAST);                   // see RL4
    sdiv_nxt = sstb_nxt ? '0 : sdiv_r + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fdiv_r <= '0;
      sdiv_r <= '0;
      fstb_r <= 1'b0;
      sstb_r <= 1'b0;
    end else begin
      fdiv_r <= fdiv_nxt;
      sdiv_r <= sdiv_nxt;
      fstb_r <= fstb_nxt;
      sstb_r <= sstb_nxt;
    end
  end

  assign fast_sample_stb = fstb_r;
  assign slow_sample_stb = sstb_r;

  // ----------------------------------------------------------------
  // fast and slow monitor units
  // ----------------------------------------------------------------
  gfs_mon_if #(.N(GFS_NFAST), .W(GFS_SMP_W)) fast_monitor_unit ();
  gfs_mon_if #(.N(GFS_NSLOW), .W(GFS_SMP_W)) slow_monitor_unit ();

  // bus voltage is one-sided; leg current checks both polarities
  assign fast_monitor_unit.sample_stb          = fstb_r;     // see RL3
  assign fast_monitor_unit.sample[GFS_F_VBUS]  = bus_voltage;
  assign fast_monitor_unit.sample[GFS_F_ILEG]  = leg_current;
  assign fast_monitor_unit.hi[GFS_F_VBUS]      = VLIM_HI;    // see RL5
  assign fast_monitor_unit.lo[GFS_F_VBUS]      = SMIN;
  assign fast_monitor_unit.hi[GFS_F_ILEG]      = ILIM_HI;    // see RL5
  assign fast_monitor_unit.lo[GFS_F_ILEG]      = ILIM_LO;    // see RL5

  assign slow_monitor_unit.sample_stb          = sstb_r;     // see RL4
  assign slow_monitor_unit.sample[GFS_S_T1]    = heatsink_temp1;
  assign slow_monitor_unit.sample[GFS_S_T2]    = heatsink_temp2;
  assign slow_monitor_unit.sample[GFS_S_SUP]   = main_supply_voltage;
  assign slow_monitor_unit.hi[GFS_S_T1]        = TLIM_HI;    // see RL5
  assign slow_monitor_unit.lo[GFS_S_T1]        = SMIN;
  assign slow_monitor_unit.hi[GFS_S_T2]        = TLIM_HI;    // see RL5
  assign slow_monitor_unit.lo[GFS_S_T2]        = SMIN;
  assign slow_monitor_unit.hi[GFS_S_SUP]       = SLIM_HI;    // see RL6
  assign slow_monitor_unit.lo[GFS_S_SUP]       = SLIM_LO;    // see RL6

  gfs_monitor #(.N(GFS_NFAST)) u_fast_mon (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .mon     (fast_monitor_unit)
  );

  gfs_monitor #(.N(GFS_NSLOW)) u_slow_mon (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .mon     (slow_monitor_unit)
  );

  // ----------------------------------------------------------------
  // fault latches and status
  // ----------------------------------------------------------------
  logic [GFS_NFLT-1:0] live;
  logic [GFS_NFLT-1:0] latch_r;
  logic [GFS_NFLT-1:0] latch_nxt;
  logic                err_n_r;
  logic                err_n_nxt;
  logic                ffast_r;
  logic                ffast_nxt;
  logic                fslow_r;
  logic                fslow_nxt;

  assign live = {slow_monitor_unit.over, fast_monitor_unit.over};

  // set beats clear, so a fault seen during the press is kept
  always_comb begin
    latch_nxt = (latch_r & ~ack_edge) | live;           // see RL10
    err_n_nxt = ~(|latch_nxt);                          // see RL9, RL11
    ffast_nxt = |latch_nxt[GFS_NFAST-1:0];              // see RL8
    fslow_nxt = |latch_nxt[GFS_NFLT-1:GFS_NFAST];       // see RL8
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      latch_r <= '0;
      err_n_r <= 1'b1;
      ffast_r <= 1'b0;
      fslow_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      err_n_r <= err_n_nxt;
      ffast_r <= ffast_nxt;
      fslow_r <= fslow_nxt;
    end
  end

  assign fault_latched  = latch_r;                      // see RL8
  assign fault_live     = live;                         // see RL8
  assign fault_fast     = ffast_r;
  assign fault_slow     = fslow_r;
  assign global_error_n = err_n_r;

  // ----------------------------------------------------------------
  // gating path
  // ----------------------------------------------------------------
  logic [GFS_NGATE-1:0] decoded;
  logic [GFS_NGATE-1:0] gate_r;
  logic [GFS_NGATE-1:0] gate_nxt;
  gfs_gmode_t           mode;

  assign mode = gfs_gmode_t'(gate_mode);

  // coded mode: per leg one command and one enable; the low switch takes
  // the complement of the command, so shoot-through cannot be coded
  always_comb begin
    decoded = GFS_GATE_BLOCK;
    unique case (mode)
      GFS_GM_DIRECT: begin
        decoded = gin_s_r;                              // see RL1
      end
      GFS_GM_CODED: begin
        decoded[GFS_G_AH] = gin_s_r[GFS_IN_EN_A] &
                            gin_s_r[GFS_IN_CMD_A];      // see RL2
        decoded[GFS_G_AL] = gin_s_r[GFS_IN_EN_A] &
                            ~gin_s_r[GFS_IN_CMD_A];
        decoded[GFS_G_BH] = gin_s_r[GFS_IN_EN_B] &
                            gin_s_r[GFS_IN_CMD_B];
        decoded[GFS_G_BL] = gin_s_r[GFS_IN_EN_B] &
                            ~gin_s_r[GFS_IN_CMD_B];
      end
    endcase
  end

  // bypass only when every latched cause allows it; else all blocked
  always_comb begin
    gate_nxt = decoded;                                 // see RL2
    if (|latch_nxt) begin                               // see RL11
      if ((latch_nxt & ~bypass_cause_mask) == '0) begin
        gate_nxt = GFS_GATE_BYPASS;                     // see RL7
      end else begin
        gate_nxt = GFS_GATE_BLOCK;                      // see RL7
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gate_r <= GFS_GATE_BLOCK;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  assign gate_out = gate_r;

endmodule : gfs_supervisor

// [testbench/gfs_sup_props.sv]
// Purpose: port-level checks of the gating and fault supervisor
// Assumes: one ref_clk domain, reset_n synchronous active low
// Notes:   bound to gfs_supervisor from the bench top file
`timescale 1ns/10ps
module gfs_sup_props
  import gfs_pkg::*;
#(
  parameter int SLOW_DIV = GFS_SLOW_DIV
) (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire logic [GFS_NGATE-1:0] opt_gate_in,
  input wire logic                 gate_mode,
  input wire logic [GFS_NFLT-1:0]  bypass_cause_mask,
  input wire logic [GFS_NFLT-1:0]  ack_btn,
  input wire logic [GFS_NGATE-1:0] gate_out,
  input wire logic                 global_error_n,
  input wire logic [GFS_NFLT-1:0]  fault_latched,
  input wire logic [GFS_NFLT-1:0]  fault_live,
  input wire logic                 fault_fast,
  input wire logic                 fault_slow,
  input wire logic                 fast_sample_stb,
  input wire logic                 slow_sample_stb
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [15:0] slow_cnt_r;
  logic [15:0] slow_cnt_nxt;
  logic        slow_seen_r;
  logic        slow_seen_nxt;

  always_comb begin
    slow_cnt_nxt  = slow_sample_stb ? 16'h0000 : slow_cnt_r + 16'h0001;
    slow_seen_nxt = slow_seen_r | slow_sample_stb;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      slow_cnt_r  <= 16'h0000;
      slow_seen_r <= 1'b0;
    end else begin
      slow_cnt_r  <= slow_cnt_nxt;
      slow_seen_r <= slow_seen_nxt;
    end
  end

  function automatic logic [3:0] exp_gate(logic m, logic [3:0] i);
    if (!m) return i;
    return {i[3] & ~i[1], i[3] & i[1], i[2] & ~i[0], i[2] & i[0]};
  endfunction : exp_gate

  // strobe period of 133 cycles, none in the first 8 cycles after a strobe
  sequence s_fast_gap;
    !fast_sample_stb [*8] ##125 fast_sample_stb;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_gate_follows_in: assert property (fault_latched == 0
    && $past(reset_n, 3) && $stable(gate_mode)
    |-> gate_out == exp_gate(gate_mode, $past(opt_gate_in, 3)))
    else $error("gate output does not follow the optical inputs");
  a_fast_period: assert property (fast_sample_stb |=> s_fast_gap)
    else $error("fast strobe spacing wrong");
  a_slow_period: assert property (slow_sample_stb && slow_seen_r
    |-> slow_cnt_r == 16'(SLOW_DIV - 1))
    else $error("slow strobe spacing wrong");
  a_force_block: assert property (
    (fault_latched & ~$past(bypass_cause_mask)) != 0
    |-> gate_out == GFS_GATE_BLOCK)
    else $error("blocked state not forced");
  a_force_bypass: assert property (fault_latched != 0
    && (fault_latched & ~$past(bypass_cause_mask)) == 0
    |-> gate_out == GFS_GATE_BYPASS)
    else $error("bypass state not forced");
  a_flag_groups: assert property (fault_fast == |fault_latched[1:0]
    && fault_slow == |fault_latched[4:2])
    else $error("group flags disagree with latches");
  a_error_low: assert property (global_error_n == ~|fault_latched)
    else $error("error output disagrees with latches");
  a_live_latches: assert property (fault_live != 0
    |=> (fault_latched & $past(fault_live)) == $past(fault_live))
    else $error("live fault not latched");
  a_clear_needs_ack: assert property (
    ($past(fault_latched) & ~fault_latched) != 0
    |-> ($past(ack_btn, 3) | $past(ack_btn, 4) | $past(ack_btn, 5)) != 0)
    else $error("latch cleared without a button");
  a_live_holds: assert property (
    !$past(fast_sample_stb)
    |-> ((fault_live ^ $past(fault_live)) & 5'h03) == 5'h00)
    else $error("fast verdict changed between strobes");
endmodule : gfs_sup_props

// [testbench/gfs_ctrl_model.sv]
// Purpose: master controller that sends gating over the optical inputs
// Assumes: pattern is set by the bench on ref_clk
// Notes:   keeps modulating during a fault, as a real controller may
`timescale 1ns/10ps
module gfs_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] pattern,
  output      logic [3:0] opt_gate_in = 4'h0
);
  // the error line is left to the bench, so gating keeps running
  always @(posedge ref_clk) begin
    opt_gate_in <= pattern;
  end
endmodule : gfs_ctrl_model

// [testbench/gfs_supervisor_bench.sv]
// Purpose: self-checking bench of the gating and fault supervisor
// Assumes: slow strobe shortened to 50 cycles
// Notes:   inputs change by non-blocking assignment on the rising edge
`timescale 1ns/10ps
module gfs_supervisor_bench;
  import gfs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  pat = 4'h0;
  logic        gate_mode = 1'b0;
  logic [4:0]  mask = 5'h00;
  logic [4:0]  ack = 5'h00;
  logic [12:0] nom [5] = '{13'h0258, 13'h0000, 13'h00FA, 13'h00FA, 13'h01F4};
  logic [12:0] smp [5] = '{13'h0258, 13'h0000, 13'h00FA, 13'h00FA, 13'h01F4};
  logic [12:0] lim [7] = '{13'h0348, 13'h00FA, 13'h1F06, 13'h0384, 13'h0384,
                           13'h01C2, 13'h0226};
  logic [12:0] bad [7] = '{13'h0349, 13'h00FB, 13'h1F05, 13'h0385, 13'h0385,
                           13'h01C1, 13'h0227};
  int          tbit [7] = '{0, 1, 1, 2, 3, 4, 4};
  logic [3:0]  c_in [6] = '{4'h5, 4'h4, 4'hA, 4'h8, 4'hF, 4'h3};
  logic [3:0]  c_ex [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h0};
  logic [3:0]  opt_gate_in;
  logic [3:0]  gate_out;
  logic        global_error_n;
  logic [4:0]  fault_latched;
  logic [4:0]  fault_live;
  logic        fault_fast;
  logic        fault_slow;
  logic        fast_sample_stb;
  logic        slow_sample_stb;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          b;

  always #25 ref_clk = ~ref_clk;

  gfs_supervisor #(.SLOW_DIV(50)) u_gfs_supervisor (
    .ref_clk(ref_clk), .reset_n(reset_n), .opt_gate_in(opt_gate_in),
    .gate_mode(gate_mode), .bypass_cause_mask(mask),
    .bus_voltage(smp[0]), .leg_current(smp[1]), .heatsink_temp1(smp[2]),
    .heatsink_temp2(smp[3]), .main_supply_voltage(smp[4]),
    .ack_btn(ack), .gate_out(gate_out), .global_error_n(global_error_n),
    .fault_latched(fault_latched), .fault_live(fault_live),
    .fault_fast(fault_fast), .fault_slow(fault_slow),
    .fast_sample_stb(fast_sample_stb), .slow_sample_stb(slow_sample_stb));

  gfs_ctrl_model u_gfs_ctrl_model (
    .ref_clk(ref_clk), .pattern(pat), .opt_gate_in(opt_gate_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_vec

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_vec(8'(got), 8'(exp));
  endtask : cmp_bit

  // wait for the strobe of the channel, then for the latch to land
  task automatic wait_smp(input int ch);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!((ch < 2) ? fast_sample_stb : slow_sample_stb) && n < 400);
    repeat (2) @(negedge ref_clk);
  endtask : wait_smp

  task automatic set_smp(input int ch, input logic [12:0] v);
    @(posedge ref_clk);
    smp[ch] <= v;
    wait_smp(ch);
  endtask : set_smp

  task automatic press(input int ch);
    @(posedge ref_clk);
    ack <= 5'(5'h01 << ch);
    repeat (5) @(posedge ref_clk);
    ack <= 5'h00;
    @(negedge ref_clk);
  endtask : press

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    cmp_bit(global_error_n, 1'b1);
    for (int i = 0; i < 16; i += 3) begin
      @(posedge ref_clk);
      pat <= 4'(i);
      repeat (5) @(negedge ref_clk);
      cmp_vec(8'(gate_out), 8'(i));
    end
    @(posedge ref_clk);
    gate_mode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      pat <= c_in[i];
      repeat (5) @(negedge ref_clk);
      cmp_vec(8'(gate_out), 8'(c_ex[i]));
    end
    @(posedge ref_clk);
    gate_mode <= 1'b0;
    pat <= 4'h6;
    for (int i = 0; i < 7; i++) begin
      b = tbit[i];
      set_smp(b, lim[i]);
      cmp_vec(8'(fault_live), 8'h00);
      set_smp(b, bad[i]);
      cmp_vec(8'(fault_latched), 8'(5'h01 << b));
      cmp_bit(global_error_n, 1'b0);
      cmp_vec(8'(gate_out), 8'h00);
      cmp_bit(fault_fast, 1'(b < 2));
      cmp_bit(fault_slow, 1'(b >= 2));
      set_smp(b, nom[b]);
      cmp_vec(8'(fault_latched), 8'(5'h01 << b));
      press(b);
      cmp_vec(8'(fault_latched), 8'h00);
      cmp_vec(8'(gate_out), 8'h06);
    end
    @(posedge ref_clk);
    mask <= 5'h01;
    set_smp(0, 13'h0349);
    cmp_vec(8'(gate_out), 8'(GFS_GATE_BYPASS));
    set_smp(2, 13'h0385);
    cmp_vec(8'(gate_out), 8'(GFS_GATE_BLOCK));
    set_smp(0, nom[0]);
    set_smp(2, nom[2]);
    press(0);
    cmp_vec(8'(fault_latched), 8'h04);
    cmp_bit(global_error_n, 1'b0);
    press(2);
    cmp_bit(global_error_n, 1'b1);
    cmp_vec(8'(gate_out), 8'h06);
    conclude();
  end
endmodule : gfs_supervisor_bench

bind gfs_supervisor gfs_sup_props #(.SLOW_DIV(SLOW_DIV)) u_gfs_sup_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .opt_gate_in(opt_gate_in),
  .gate_mode(gate_mode), .bypass_cause_mask(bypass_cause_mask),
  .ack_btn(ack_btn), .gate_out(gate_out), .global_error_n(global_error_n),
  .fault_latched(fault_latched), .fault_live(fault_live),
  .fault_fast(fault_fast), .fault_slow(fault_slow),
  .fast_sample_stb(fast_sample_stb), .slow_sample_stb(slow_sample_stb));
